// file: logic/pda_pkg.sv
// Package with constants and bus types for the pipeline delay alignment block.
`default_nettype none
package pda_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BLINK  = 8'h08;

    // Control register fields and reset value.
    localparam int          CTRL_ALIGN_EN_BIT = 0;
    localparam int          CTRL_BLINK_EN_BIT = 1;
    localparam logic [1:0]  CTRL_RESET        = 2'h3;

    // Status register field positions.
    localparam int STAT_ALIGNED_BIT = 0;
    localparam int STAT_HALTED_BIT  = 1;
    localparam int STAT_HCNT_LSB    = 4;
    localparam int STAT_LAT_LSB     = 8;

    // Pipeline latency figures in pixel clock cycles.
    localparam int          LAT_MIN     = 11;
    localparam int          LAT_MAX     = 15;
    localparam logic [3:0]  LAT_ALIGNED = 4'hd;

    // Load strobe rising edges needed while the clock is held.
    localparam logic [1:0]  HALT_EDGES = 2'h3;

    // Register bus request carried as one group.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pda_bus_req_t;

endpackage
`default_nettype wire

// file: logic/pda_align.sv
// Pixel pipeline with clock-stop latency alignment, blink counter and register port.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RL1] The outside generator makes the load strobe by dividing the pixel clock by two or four.
// [RL2] The load strobe may sit at any phase to the pixel clock and the block does not rely on it.
// [RL3] The outside system may reuse the load strobe for memory shifting and video timing.
// [RL4] Before alignment the pixel latency is a fixed value from 11 to 15 pixel clock cycles.
// [RL5] After a completed alignment the pixel latency is exactly 13 pixel clock cycles.
// [RL6] The generator starts the alignment with power on and all clocks toggling.
// [RL7] The clock is held true high and complement low for at least three load strobe rising edges.
// [RL8] The clock may be held for any length of time before the restart.
// [RL9] The first falling clock edge on restart lies close to a load strobe rising edge.
// [RL10] The generator keeps every restart clock phase at least the minimum pulse width.
// [RL11] Alignment leaves the blink counter untouched.
// [RL12] Software with several devices blinks through the read mask instead of the blink logic.
// [RL13] The generator counts load strobe edges while halted before releasing the clock.
module pda_align #(
    parameter int PIX_W       = 28,
    parameter int POWERUP_LAT = 11,
    parameter int BLINK_W     = 16
) (
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    // Clock and strobe pins from the generator.
    input  wire logic                    pixClk,
    input  wire logic                    pixClkN,
    input  wire logic                    load_strobe_n,
    // Pixel port.
    input  wire logic [PIX_W-1:0]        pixIn,
    output logic      [PIX_W-1:0]        pixOut,
    // Status outputs.
    output logic                         aligned,
    output logic                         blinkPhase,
    // Register port.
    input  wire pda_pkg::pda_bus_req_t   busReq,
    output logic [pda_pkg::DATA_W-1:0]   rdData
);

    // Refuse parameter values the delay line, the blink counter or the read port cannot serve.
    initial begin
        if (POWERUP_LAT < pda_pkg::LAT_MIN || POWERUP_LAT > pda_pkg::LAT_MAX) begin
            $error("POWERUP_LAT out of range");
        end
        if (PIX_W < 1 || BLINK_W < 2) begin
            $error("Width parameter too small");
        end
        // The blink counter is read back through one data word, so it must fit in it.
        if (BLINK_W > pda_pkg::DATA_W) begin
            $error("BLINK_W wider than the register data word");
        end
    end

    localparam int DEPTH = pda_pkg::LAT_MAX;
    localparam logic [3:0] LAT_RESET = 4'(POWERUP_LAT);

    // A hold is armed once the strobe count has reached the required minimum.
    // The status view, the saturation and the restart decode all use this one
    // decode, so they cannot drift apart if the minimum is ever changed.
    function automatic logic holdArmed(input logic [1:0] cnt);
        return cnt == pda_pkg::HALT_EDGES;
    endfunction

    // The restart that fixes the latency is the first clock fall of an armed hold
    // while alignment is enabled.  The strobe phase at that moment is not looked at,
    // because the generator may place the strobe at any offset to the clock.
    function automatic logic alignFire(input logic fall, input logic [1:0] cnt, input logic en);
        return fall && holdArmed(cnt) && en;
    endfunction

    typedef struct packed {
        logic [2:0]                     clkSync;
        logic [2:0]                     clkNSync;
        logic [2:0]                     ldSync;
        logic [1:0][PIX_W-1:0]          pixSync;
        logic [DEPTH-1:0][PIX_W-1:0]    line;
        logic [PIX_W-1:0]               out;
        logic [3:0]                     lat;
        logic [1:0]                     haltCnt;
        logic                           alignedFlag;
        logic [1:0]                     ctrl;
        logic [BLINK_W-1:0]             blinkCnt;
        logic [pda_pkg::DATA_W-1:0]     rd;
    } pda_state_t;

    pda_state_t st_q;
    pda_state_t st_d;

    logic clkRise;
    logic clkFall;
    logic ldRise;
    logic heldHigh;

    // Edge detection looks only at the second and third sync stages.
    // The first stage may still be settling after a pin change, so nothing but
    // the next stage reads it; an edge is therefore seen three clocks after the pin.
    // The hold test needs both clock phases, so a single-ended stop is not taken.
    assign clkRise  = st_q.clkSync[1] & ~st_q.clkSync[2];
    assign clkFall  = ~st_q.clkSync[1] & st_q.clkSync[2];
    assign ldRise   = st_q.ldSync[1] & ~st_q.ldSync[2];
    assign heldHigh = st_q.clkSync[2] & ~st_q.clkNSync[2];

    // Next-state logic for the whole block.
    always_comb begin
        st_d = st_q;
        st_d.clkSync  = {st_q.clkSync[1:0], pixClk};
        st_d.clkNSync = {st_q.clkNSync[1:0], pixClkN};
        st_d.ldSync   = {st_q.ldSync[1:0], load_strobe_n};
        st_d.pixSync  = {st_q.pixSync[0], pixIn};

        // Delay line advances on each pixel clock rising edge; the tap sets the latency.
        // The output takes the old content of tap lat-1, so a pixel sampled at one
        // rise appears exactly lat rises later.  The line is as deep as the longest
        // latency, so every legal tap lies inside it.
        if (clkRise) begin
            st_d.line = {st_q.line[DEPTH-2:0], st_q.pixSync[1]};
            st_d.out  = st_q.line[st_q.lat - 4'h1]; // see [RL4] see [RL5]
        end

        // Count strobe rising edges while the clock is held high and its complement low; any clock edge restarts the count.
        if (clkRise || clkFall) begin
            st_d.haltCnt = 2'h0;
        end else if (ldRise && heldHigh && !holdArmed(st_q.haltCnt)) begin
            st_d.haltCnt = st_q.haltCnt + 2'h1; // see [RL7]
        end
        // The count saturates, so a hold of any length stays armed.  see [RL8]

        // First falling edge after a long enough hold fixes the latency.
        // Strobe phase against the clock is not checked.  see [RL2]
        // The restart window itself is the generator's duty and is not policed here.
        if (alignFire(clkFall, st_q.haltCnt, st_q.ctrl[pda_pkg::CTRL_ALIGN_EN_BIT])) begin
            st_d.lat = pda_pkg::LAT_ALIGNED; // see [RL5]
        end

        // Blink counter runs on strobe edges and ignores alignment.
        // Several blocks in parallel therefore keep unrelated blink phases.
        if (ldRise && st_q.ctrl[pda_pkg::CTRL_BLINK_EN_BIT]) begin
            st_d.blinkCnt = st_q.blinkCnt + 1'b1; // see [RL11]
        end

        // Register writes; a write of one clears the aligned flag.
        if (busReq.wr) begin
            case (busReq.addr)
                pda_pkg::OFS_CTRL: begin
                    st_d.ctrl = busReq.wdata[1:0];
                end
                pda_pkg::OFS_STATUS: begin
                    if (busReq.wdata[pda_pkg::STAT_ALIGNED_BIT]) begin
                        st_d.alignedFlag = 1'b0;
                    end
                end
                default: begin
                    st_d.ctrl = st_d.ctrl;
                end
            endcase
        end

        // Setting the aligned flag wins over a clear in the same cycle.
        // This comes after the write decode on purpose, so a clear that meets
        // the restart cannot lose a completed alignment.
        if (alignFire(clkFall, st_q.haltCnt, st_q.ctrl[pda_pkg::CTRL_ALIGN_EN_BIT])) begin
            st_d.alignedFlag = 1'b1; // see [RL5]
        end

        // Read data stands in the cycle after the strobe only.
        // Clearing it in every other cycle keeps the bus quiet between reads
        // and makes an unmapped address read back as zero.
        st_d.rd = '0;
        if (busReq.rd) begin
            case (busReq.addr)
                pda_pkg::OFS_CTRL: begin
                    st_d.rd[1:0] = st_q.ctrl;
                end
                pda_pkg::OFS_STATUS: begin
                    st_d.rd[pda_pkg::STAT_ALIGNED_BIT] = st_q.alignedFlag;
                    st_d.rd[pda_pkg::STAT_HALTED_BIT]  = holdArmed(st_q.haltCnt);
                    st_d.rd[pda_pkg::STAT_HCNT_LSB +: 2] = st_q.haltCnt;
                    st_d.rd[pda_pkg::STAT_LAT_LSB +: 4]  = st_q.lat;
                end
                pda_pkg::OFS_BLINK: begin
                    st_d.rd[BLINK_W-1:0] = st_q.blinkCnt;
                end
                default: begin
                    st_d.rd = '0;
                end
            endcase
        end
    end

    // State register.
    // Reset loads only constants: power-up latency, control defaults, all else zero.
    // The pixel pins need three clocks after release before any edge is seen.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q          <= '0;
            st_q.lat      <= LAT_RESET;
            st_q.ctrl     <= pda_pkg::CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register.
    // No output passes through logic, so each one changes only at a clock edge or at reset.
    assign pixOut     = st_q.out;
    assign aligned    = st_q.alignedFlag;
    assign blinkPhase = st_q.blinkCnt[BLINK_W-1];
    assign rdData     = st_q.rd;

endmodule
`default_nettype wire

// file: verification/pda_align_asserts.sv
// Concurrent checks on the alignment block ports.
`timescale 1ns/1ps
`default_nettype none
module pda_align_asserts #(parameter int PIX_W = 28) (
    // Clock, reset and pins.
    input wire logic                        sys_clk,
    input wire logic                        resetn,
    input wire logic                        pixClk,
    input wire logic                        pixClkN,
    input wire logic                        load_strobe_n,
    input wire logic [PIX_W-1:0]            pixIn,
    // Outputs and register port.
    input wire logic [PIX_W-1:0]            pixOut,
    input wire logic                        aligned,
    input wire logic                        blinkPhase,
    input wire pda_pkg::pda_bus_req_t       busReq,
    input wire logic [pda_pkg::DATA_W-1:0]  rdData
);
    // All checks run on the system clock and rest during reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    read_idle_a: assert property (!$past(busReq.rd) |-> rdData == 0) else $error("rdData not idle");
    hole_read_a: assert property ($past(busReq.rd) && $past(busReq.addr) == 8'h0c |-> rdData == 0)
        else $error("unmapped read not zero");
    align_sticky_a:
        assert property ($past(aligned) && !$past(busReq.wr) |-> aligned) else $error("aligned dropped");
    align_fall_a:
        assert property ($rose(aligned) |-> !$past(pixClk, 2)) else $error("aligned without clock fall");
    blink_strobe_a:
        assert property ($changed(blinkPhase) |-> load_strobe_n) else $error("blink moved without strobe");
    pix_update_a:
        assert property ($changed(pixOut) |-> $past(pixClk, 2)) else $error("pixOut moved off clock rise");
    cover property ($rose(aligned));
    cover property (busReq.rd ##1 rdData != 0);
    cover property ($changed(blinkPhase));
endmodule
`default_nettype wire

// file: verification/pda_gen_model.sv
// Behavioural clock and load strobe generator beside the alignment block.
`timescale 1ns/1ps
`default_nettype none
module pda_gen_model #(parameter int DIV = 4) (
    // Hold request.
    input  wire logic halt,
    // Generated pins.
    output logic      pixClk,
    output logic      pixClkN,
    output logic      load_strobe_n
);
    int   ph = 0, edges = 0;
    logic stopped = 0, rise;
    assign pixClkN = ~pixClk;
    // Half-period ticks of 24 ns drive the clock and the strobe.
    initial begin
        pixClk = 1;
        load_strobe_n = 1;
        forever begin
            #24 ph++;
            rise = 0;
            if (ph % DIV == 0) begin
                load_strobe_n = ~load_strobe_n;
                rise = load_strobe_n;
            end
            if (stopped && rise) begin
                if (!halt && edges == 3) stopped = 0;
                else if (edges < 3) edges++;
            end
            if (!stopped) begin
                pixClk = ~pixClk;
                stopped = halt && pixClk;
                edges = 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the alignment block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  sys_clk = 0, resetn = 0, halt = 0, rdPend = 0, pc;
    logic                  pixClk, pixClkN, load_strobe_n, aligned, blinkPhase;
    logic [27:0]           pixIn = 0, pixOut, hist [int];
    logic [31:0]           rdData, seed = 32'h697a1181, q [$];
    pda_pkg::pda_bus_req_t busReq = '0;
    int                    err_count = 0, compares = 0, n = 0, lat = 15;
    pda_gen_model gen (.halt, .pixClk, .pixClkN, .load_strobe_n);
    pda_align #(.POWERUP_LAT(15), .BLINK_W(2)) dut (.sys_clk, .resetn, .pixClk, .pixClkN,
        .load_strobe_n, .pixIn, .pixOut, .aligned, .blinkPhase, .busReq, .rdData);
    initial forever #2.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    // One bus cycle; a read notes its expected data, the last call of a group idles.
    task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
        if (r) q.push_back(d);
        busReq <= '{w, r, a, w ? d : 32'h0};
        @(posedge sys_clk);
    endtask
    task automatic hold(logic [31:0] st);
        halt <= 1;
        repeat (200) @(posedge sys_clk);
        bus(0, 1, pda_pkg::OFS_STATUS, st);
        halt <= 0;
        bus(0, 0, 8'h0, 0);
        repeat (400) @(posedge sys_clk);
    endtask
    task automatic final_report;
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watcher: read data, pixel latency and fresh pixels on each clock fall.
    always @(posedge sys_clk) begin
        rdPend <= busReq.rd;
        if (rdPend) chk("rdData", q.pop_front(), rdData);
        pc <= pixClk;
        if (!pc && pixClk) begin
            hist[n] = pixIn;
            n++;
        end
        if (pc && !pixClk) begin
            if (n > lat) chk("pixOut", {4'h0, hist[n-1-lat]}, {4'h0, pixOut});
            seed = lfsr(seed);
            pixIn <= seed[27:0];
        end
        if (aligned === 1'b1) lat = 13;
    end
    // Main sequence: refused alignment, real alignment, then clearing the flag.
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1;
        bus(0, 1, pda_pkg::OFS_CTRL, 32'h3);
        bus(0, 1, 8'h0c, 32'h0);
        bus(1, 0, pda_pkg::OFS_CTRL, 32'h2);
        bus(0, 1, pda_pkg::OFS_CTRL, 32'h2);
        bus(0, 0, 8'h0, 0);
        repeat (400) @(posedge sys_clk);
        hold(32'h0f32);
        bus(0, 1, pda_pkg::OFS_STATUS, 32'h0f00);
        bus(1, 0, pda_pkg::OFS_CTRL, 32'h3);
        bus(0, 0, 8'h0, 0);
        hold(32'h0f32);
        bus(0, 1, pda_pkg::OFS_STATUS, 32'h0d01);
        bus(1, 0, pda_pkg::OFS_STATUS, 32'h1);
        bus(0, 1, pda_pkg::OFS_STATUS, 32'h0d00);
        bus(0, 0, 8'h0, 0);
        repeat (400) @(posedge sys_clk);
        final_report;
    end
    initial begin
        #50000;
        err_count++;
        final_report;
    end
endmodule
bind pda_align pda_align_asserts #(.PIX_W(PIX_W)) chk_i (.sys_clk, .resetn, .pixClk, .pixClkN,
    .load_strobe_n, .pixIn, .pixOut, .aligned, .blinkPhase, .busReq, .rdData);
`default_nettype wire
